// ---- src/psb_status.sv ----
// byte buffer status for a parallel slave port: four in, four out
// assumes host requests and cpu strobes are on clk, same domain
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module psb_status
	import psb_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	// register port
	input  wire logic [PSB_ADDR_W-1:0] regAddr,
	input  wire logic [31:0]           regWdata,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	output logic      [31:0]           regRdata,
	// host side request stream, buffered
	input  wire psb_host_req_t         hostReq,
	input  wire logic                  hostValid,
	output logic                       hostReady,
	// host read answers
	output logic      [7:0]            hostRdata,
	output logic                       hostRvalid,
	input  wire logic                  hostRready,
	// cpu byte access to the slots
	input  wire logic [1:0]            cpuSlot,
	input  wire logic                  cpuInRd,
	output logic      [7:0]            cpuInData,
	input  wire logic                  cpuOutWr,
	input  wire logic [7:0]            cpuOutData,
	output logic                       slaveMode
);
	// slot flags, errors and mode
	logic [3:0]     inFull_q;
	logic [3:0]     outEmpty_q;
	logic           inOvf_q;
	logic           outUnf_q;
	logic           slave_q;

	// slot storage and the request buffer
	logic [7:0]     inBuf_q  [PSB_SLOTS];
	logic [7:0]     outBuf_q [PSB_SLOTS];
	psb_host_req_t  fifo_q   [2];
	logic [1:0]     fifoCnt_q;
	logic           fifoRp_q;
	logic           fifoWp_q;
	psb_host_req_t  head;
	logic           headValid;
	logic           headTake;
	logic           hostPush;

	// decoded host and register events
	logic           hostWrReq;
	logic           hostRdReq;
	logic           hostWrOk;
	logic           hostWrOvf;
	logic           hostRdOk;
	logic           hostRdUnf;
	logic           clrWr;
	logic           clrOvf;
	logic           clrUnf;
	logic           ctrlWr;

	// read side values
	logic           inAllFull;
	logic           outAllEmpty;
	logic [31:0]    statusWord;
	logic [31:0]    rdMux;
	logic [7:0]     rdata_q;
	logic           rvalid_q;

	// two-entry request buffer; ready drops when both entries are used
	assign hostReady = (fifoCnt_q != 2'd2);
	assign head      = fifo_q[fifoRp_q];
	assign headValid = (fifoCnt_q != 2'd0);
	// a read answer slot must be free before a request retires
	assign headTake  = headValid && (!rvalid_q || hostRready);

	// a request enters when offered and there is room
	assign hostPush  = hostValid && hostReady;

	// write pointer moves on every accepted request
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			fifoWp_q <= 1'b0;
		else if (hostPush)
			fifoWp_q <= ~fifoWp_q;
	end

	// read pointer moves as the head retires
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			fifoRp_q <= 1'b0;
		else if (headTake)
			fifoRp_q <= ~fifoRp_q;
	end

	// fill count; a push beside a pop leaves it alone
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			fifoCnt_q <= 2'd0;
		else
			unique case ({hostPush, headTake})
				2'b10:   fifoCnt_q <= fifoCnt_q + 2'd1;
				2'b01:   fifoCnt_q <= fifoCnt_q - 2'd1;
				default: fifoCnt_q <= fifoCnt_q;
			endcase
	end

	// entries need no reset, the count guards them
	always_ff @(posedge clk)
	begin
		if (hostPush)
			fifo_q[fifoWp_q] <= hostReq;
	end

	// decode the retiring host request
	assign hostWrReq = headTake && head.write;
	assign hostRdReq = headTake && !head.write;
	assign hostWrOk  = hostWrReq && !inFull_q[head.slot];
	assign hostWrOvf = hostWrReq && inFull_q[head.slot];
	assign hostRdOk  = hostRdReq && !outEmpty_q[head.slot];
	assign hostRdUnf = hostRdReq && outEmpty_q[head.slot];

	// input slot data; cleared so an early cpu read shows no unknown
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < PSB_SLOTS; i++)
				inBuf_q[i] <= 8'h00;
		end
		else if (hostWrOk)
			inBuf_q[head.slot] <= head.data;
	end

	// per-slot input full flags
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			inFull_q <= PSB_RST_IN_FULL;
		else
		begin
			for (int i = 0; i < PSB_SLOTS; i++)
			begin
				// host set beats a same-cycle cpu read clear
				if (hostWrOk && head.slot == 2'(i))
					inFull_q[i] <= 1'b1;
				else if (cpuInRd && cpuSlot == 2'(i))
					inFull_q[i] <= 1'b0;
			end
		end
	end

	// cpu reads the selected input byte
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cpuInData <= 8'h00;
		else if (cpuInRd)
			cpuInData <= inBuf_q[cpuSlot];
	end

	// output slot data written by the cpu
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < PSB_SLOTS; i++)
				outBuf_q[i] <= 8'h00;
		end
		else if (cpuOutWr)
			outBuf_q[cpuSlot] <= cpuOutData;
	end

	// per-slot output empty flags
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			outEmpty_q <= PSB_RST_OUT_EMPTY;
		else
		begin
			for (int i = 0; i < PSB_SLOTS; i++)
			begin
				// host take sets empty; cpu write in same cycle refills
				if (cpuOutWr && cpuSlot == 2'(i))
					outEmpty_q[i] <= 1'b0;
				else if (hostRdOk && head.slot == 2'(i))
					outEmpty_q[i] <= 1'b1;
			end
		end
	end

	// answer valid holds until the host takes it
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rvalid_q <= 1'b0;
		else if (hostRdReq)
			rvalid_q <= 1'b1;
		else if (hostRready)
			rvalid_q <= 1'b0;
	end

	// answer byte; underflow returns zero and leaves the slot alone
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rdata_q <= 8'h00;
		else if (hostRdReq)
			rdata_q <= hostRdOk ? outBuf_q[head.slot] : 8'h00;
	end
	assign hostRdata  = rdata_q;
	assign hostRvalid = rvalid_q;

	// software clear of sticky errors through the clear register
	assign clrWr  = regWr && regAddr == PSB_OFS_CLEAR;
	assign clrOvf = clrWr && regWdata[PSB_BIT_IN_OVERFLOW];
	assign clrUnf = clrWr && regWdata[PSB_BIT_OUT_UNDERFLOW];
	assign ctrlWr = regWr && regAddr == PSB_OFS_CONTROL;

	// sticky overflow; a new event wins over the clear
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			inOvf_q <= 1'b0;
		else if (hostWrOvf)
			inOvf_q <= 1'b1;
		else if (clrOvf)
			inOvf_q <= 1'b0;
	end

	// sticky underflow; same priority as the overflow flag
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			outUnf_q <= 1'b0;
		else if (hostRdUnf)
			outUnf_q <= 1'b1;
		else if (clrUnf)
			outUnf_q <= 1'b0;
	end

	// slave mode control; status only has meaning while set
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			slave_q <= PSB_RST_SLAVE;
		else if (ctrlWr)
			slave_q <= regWdata[PSB_BIT_SLAVE_MODE];
	end
	assign slaveMode = slave_q;

	// aggregate flags over all four slots
	assign inAllFull   = &inFull_q;
	assign outAllEmpty = &outEmpty_q;

	// status word assembly; unused bits tied low
	always_comb
	begin
		statusWord = 32'h0000_0000;
		if (slave_q)
		begin
			statusWord[PSB_BIT_IN_ALL_FULL]   = inAllFull;
			statusWord[PSB_BIT_IN_OVERFLOW]   = inOvf_q;
			statusWord[PSB_LSB_IN_SLOT_FULL +: PSB_SLOTS] = inFull_q;
			statusWord[PSB_BIT_OUT_ALL_EMPTY] = outAllEmpty;
			statusWord[PSB_BIT_OUT_UNDERFLOW] = outUnf_q;
			statusWord[PSB_LSB_OUT_SLOT_EMPTY +: PSB_SLOTS] = outEmpty_q;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb
	begin
		rdMux = 32'h0000_0000;
		unique case (regAddr)
			PSB_OFS_STATUS:  rdMux = statusWord;
			PSB_OFS_CONTROL: rdMux = {31'h0, slave_q};
			default:         rdMux = 32'h0000_0000;
		endcase
	end

	// register read data, one cycle after the strobe, else zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			regRdata <= 32'h0000_0000;
		else if (regRd)
			regRdata <= rdMux;
		else
			regRdata <= 32'h0000_0000;
	end
endmodule : psb_status

// ---- src/psb_pkg.sv ----
// package for the parallel slave buffer status block
// assumes a plain register port with one-cycle strobes
package psb_pkg;
	localparam int PSB_ADDR_W = 4;
	localparam int PSB_SLOTS  = 4;
	// register offsets (byte addresses)
	localparam logic [3:0] PSB_OFS_STATUS  = 4'h0;
	localparam logic [3:0] PSB_OFS_CONTROL = 4'h4;
	localparam logic [3:0] PSB_OFS_CLEAR   = 4'h8;
	// status field positions
	localparam int PSB_BIT_IN_ALL_FULL   = 15;
	localparam int PSB_BIT_IN_OVERFLOW   = 14;
	localparam int PSB_LSB_IN_SLOT_FULL  = 8;
	localparam int PSB_BIT_OUT_ALL_EMPTY = 7;
	localparam int PSB_BIT_OUT_UNDERFLOW = 6;
	localparam int PSB_LSB_OUT_SLOT_EMPTY = 0;
	// control field positions
	localparam int PSB_BIT_SLAVE_MODE = 0;
	// reset values
	localparam logic [3:0] PSB_RST_IN_FULL   = 4'h0;
	localparam logic [3:0] PSB_RST_OUT_EMPTY = 4'hF;
	localparam logic       PSB_RST_SLAVE     = 1'b1;

	// one host access toward a slot
	typedef struct packed {
		logic       write;
		logic [1:0] slot;
		logic [7:0] data;
	} psb_host_req_t;
endpackage : psb_pkg

// ---- tb/psb_status_checker.sv ----
// port assertions for the slot status block
// assumes it is bound onto psb_status, one clock domain
`timescale 1ns/1ps
module psb_status_checker
	import psb_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  sys_rst,
	input wire logic [PSB_ADDR_W-1:0] regAddr,
	input wire logic [31:0]           regWdata,
	input wire logic                  regWr,
	input wire logic                  regRd,
	input wire logic [31:0]           regRdata,
	input wire logic                  hostRvalid,
	input wire logic                  hostRready,
	input wire logic                  slaveMode
);
	logic stRd_q;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// marks the answer cycle of a status read
	always_ff @(posedge clk)
		stRd_q <= regRd && regAddr == PSB_OFS_STATUS;
	property p_quiet; !$past(regRd) |-> regRdata == 32'h0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("stray read data");
	property p_unimp; $past(regRd) |-> (regRdata & 32'hFFFF3030) == 32'h0;
	endproperty
	a_unimp: assert property (p_unimp) else $error("unused bit set");
	property p_full; stRd_q |-> regRdata[15] == &regRdata[11:8];
	endproperty
	a_full: assert property (p_full) else $error("all full wrong");
	property p_empty; stRd_q |-> regRdata[7] == &regRdata[3:0];
	endproperty
	a_empty: assert property (p_empty) else $error("all empty wrong");
	property p_off; stRd_q && !$past(slaveMode) |-> regRdata == 32'h0;
	endproperty
	a_off: assert property (p_off) else $error("status when off");
	property p_modewr; regWr && regAddr == PSB_OFS_CONTROL |=>
		slaveMode == $past(regWdata[0]);
	endproperty
	a_modewr: assert property (p_modewr) else $error("mode write");
	property p_modekeep; !$past(regWr) |-> $stable(slaveMode);
	endproperty
	a_modekeep: assert property (p_modekeep) else $error("mode moved");
	property p_hold; hostRvalid && !hostRready |=> hostRvalid;
	endproperty
	a_hold: assert property (p_hold) else $error("answer dropped");
endmodule : psb_status_checker

bind psb_status psb_status_checker chk (.*);

// ---- tb/psb_host_model.sv ----
// external host: byte writes and reads toward the slots
// assumes the status block clock; stall holds off answers
`timescale 1ns/1ps
module psb_host_model
	import psb_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       hostReady,
	input  wire logic       hostRvalid,
	input  wire logic [7:0] hostRdata,
	input  wire logic       stall,
	output psb_host_req_t   hostReq,
	output logic            hostValid,
	output logic            hostRready,
	output logic [7:0]      got
);
	initial
	begin
		hostReq = '0;
		hostValid = 1'b0;
		got = 8'hEE;
	end
	// a slow host only delays taking answers
	assign hostRready = !stall;
	// byte kept at the edge the answer is taken
	always @(posedge clk)
		if (hostRvalid && hostRready)
			got <= hostRdata;
	task send(input psb_host_req_t r);
		@(posedge clk);
		hostValid <= 1'b1;
		hostReq <= r;
		@(posedge clk);
		while (!hostReady)
			@(posedge clk);
		hostValid <= 1'b0;
		hostReq <= ~r; // released lines toggle, never stale
	endtask : send
endmodule : psb_host_model

// ---- tb/psb_status_tb_top.sv ----
// self-checking bench for the slot status block
// assumes host model and checker are compiled alongside
`timescale 1ns/1ps
module psb_status_tb_top;
	import psb_pkg::*;
	typedef struct packed {psb_host_req_t req; logic [31:0] exp;} psb_row_t;
	logic [3:0] regAddr;
	logic [1:0] cpuSlot = 2'h0;
	logic [31:0] regWdata, regRdata, rd;
	logic [7:0] hostRdata, cpuInData, cpuOutData, got;
	logic clk, sys_rst, regWr, regRd, hostValid, hostRready, hostRvalid;
	logic hostReady, cpuInRd, cpuOutWr, slaveMode, stall;
	psb_host_req_t hostReq;
	int error_cnt, comparisons, cyc;
	psb_row_t rows[6] = '{'{'{1'b1, 2'h0, 8'hA0}, 32'h0000018F},
		'{'{1'b1, 2'h1, 8'hA1}, 32'h0000038F}, '{'{1'b1, 2'h2, 8'hA2}, 32'h0000078F},
		'{'{1'b1, 2'h3, 8'hA3}, 32'h00008F8F}, '{'{1'b1, 2'h0, 8'h5A}, 32'h0000CF8F},
		'{'{1'b0, 2'h2, 8'h00}, 32'h0000CFCF}};
	psb_status dut (.*);
	psb_host_model host (.*);
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			error_cnt++;
			test_done();
		end
	end
	task test_done();
		$display("checks %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	task check(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask : check
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		{regWr, regRd, regAddr, regWdata} <= {w, !w, a, d};
		@(posedge clk);
		{regWr, regRd} <= 2'h0;
		#1 rd = regRdata;
	endtask : bus
	task st(input logic [31:0] e);
		repeat (2) @(posedge clk);
		bus(1'b0, PSB_OFS_STATUS, 32'h0);
		check(rd, e);
	endtask : st
	initial
	begin
		{regWr, regRd, cpuInRd, cpuOutWr, stall, cyc} = '0;
		{regAddr, regWdata, cpuOutData, error_cnt, comparisons} = '0;
		sys_rst = 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		st(32'h0000008F);
		foreach (rows[i])
		begin
			host.send(rows[i].req);
			st(rows[i].exp);
		end
		check(got, 8'h00);
		bus(1'b1, PSB_OFS_CLEAR, 32'h00004040);
		st(32'h00008F8F);
		@(posedge clk) {cpuInRd, cpuSlot} <= 3'h4;
		@(posedge clk) cpuInRd <= 1'b0;
		#1 check(cpuInData, 8'hA0);
		st(32'h00000E8F);
		@(posedge clk) {cpuOutWr, cpuSlot, cpuOutData} <= 11'h53C;
		@(posedge clk) cpuOutWr <= 1'b0;
		st(32'h00000E0D);
		// stalled host fills the request buffer until it refuses
		stall <= 1'b1;
		repeat (2) host.send('{1'b0, 2'h3, 8'h00});
		host.send('{1'b0, 2'h1, 8'h00});
		repeat (2) @(posedge clk);
		check({hostReady, hostRvalid}, 2'h1);
		stall <= 1'b0;
		st(32'h00000ECF);
		check(got, 8'h3C);
		bus(1'b1, PSB_OFS_CONTROL, 32'h0);
		st(32'h0);
		bus(1'b1, PSB_OFS_CONTROL, 32'h1);
		bus(1'b0, 4'hC, 32'h0);
		check(rd, 32'h0);
		// mid-run reset brings every flag back to its idle value
		@(posedge clk) sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		st(32'h0000008F);
		check({hostReady, hostRvalid, cpuInData}, 10'h200);
		test_done();
	end
endmodule : psb_status_tb_top
